// *** rtl/tws_slave.sv ***
// two-wire bus slave: protocol engine on link_clk, register side on ref_clk
// assumes an external pull-up on the data wire and a user register file on ref_clk
// Overview of operation
// R1: always a slave, up to 100 kbit/s
// R2: SDA falls while SCL high: START
// R3: SDA rises while SCL high: STOP, idle
// R4: busy from START until STOP
// R5: repeated START restarts address reception
// R6: SDA changes only while SCL low
// R7: master makes every SCL pulse
// R8: drive SDA only for ACK or read data
// R9: master shifts on fall, samples on rise
// R10: eight bits MSB first, then ack bit
// R11: receiver acknowledges each byte, ninth clock
// R12: master stops or restarts after slave NACK
// R13: master NACK ends read, slave releases
// R14: master clocks every acknowledge bit
// R15: first byte holds seven-bit address
// R16: address LSB one means read
// R17: on match, ack and set direction
// R18: answer only to address 0x74
// R19: data pin open drain, low only
// R20: write: register address, data, then STOP
// R21: read: pointer, repeated START, then bytes from the pointer on until master NACK
// R22: pins synchronised and filtered before decoding
// R23: foreign address: release SDA, wait
`timescale 1ns/1ns
module tws_slave
  import tws_pkg::*;
(
  // core clock and reset
  input  wire logic    ref_clk,
  input  wire logic    rst,
  // link clock
  input  wire logic    link_clk,
  // bus pins
  input  wire logic    serial_clock_pin,
  input  wire logic    serial_data_pin_i,
  output logic         serial_data_pin_o,
  output logic         serial_data_pin_oe,
  // register write side
  output logic         wr_valid,
  output tws_wr_s      wr_cmd,
  // register read side
  output logic         rd_req,
  output logic [7:0]   rd_addr,
  input  wire logic [7:0] rd_data,
  // status
  output logic         bus_busy
);
  // link-domain reset: async assert, released in step with link_clk
  logic       lrst_reg;
  tws_sync #(.W(1), .INIT(1'b1)) u_rst_sync (
    .clk (link_clk),
    .rst (rst),
    .d   (1'b0),
    .q   (lrst_reg)
  );

  // link-side state
  tws_state_e st_reg,      st_next;
  logic [3:0] cnt_reg,     cnt_next;
  logic [7:0] sh_reg,      sh_next;
  logic       dir_reg,     dir_next;
  logic       first_reg,   first_next;
  logic [7:0] ptr_reg,     ptr_next;
  logic       oe_reg,      oe_next;
  logic       busy_reg,    busy_next;
  logic       wtgl_reg,    wtgl_next;
  tws_wr_s    wcmd_reg,    wcmd_next;
  logic       rtgl_reg,    rtgl_next;
  logic [7:0] rptr_reg,    rptr_next;
  logic [7:0] rbyte_reg,   rbyte_next;
  logic       scl_p_reg;
  logic       sda_p_reg;
  logic       rda_p_reg;
  // ref-side state
  logic       wr_valid_reg, wr_valid_next;
  tws_wr_s    wr_cmd_reg,   wr_cmd_next;
  logic       rd_req_reg,   rd_req_next;
  logic [7:0] rd_addr_reg,  rd_addr_next;
  logic       rd_pend_reg,  rd_pend_next;
  logic [7:0] rhold_reg,    rhold_next;
  logic       atgl_reg,     atgl_next;
  logic       wtgl_p_reg;
  logic       rtgl_p_reg;

  // synchronised views
  logic [2:0] link_s;
  logic [2:0] ref_s;
  wire logic  scl_f  = link_s[2];
  wire logic  sda_f  = link_s[1];
  wire logic  rda_s  = link_s[0];
  wire logic  busy_s = ref_s[2];
  wire logic  wtgl_s = ref_s[1];
  wire logic  rtgl_s = ref_s[0];

  tws_sync #(.W(3), .INIT(TWS_LINK_SYNC_RST)) u_link_sync ( // R22
    .clk (link_clk),
    .rst (lrst_reg),
    .d   ({serial_clock_pin, serial_data_pin_i, atgl_reg}),
    .q   (link_s)
  );
  tws_sync #(.W(3), .INIT(TWS_REF_SYNC_RST)) u_ref_sync (
    .clk (ref_clk),
    .rst (rst),
    .d   ({busy_reg, wtgl_reg, rtgl_reg}),
    .q   (ref_s)
  );

  // bus events from filtered levels
  wire logic  scl_rise  = scl_f & ~scl_p_reg;
  wire logic  scl_fall  = ~scl_f & scl_p_reg;
  wire logic  start_det = scl_f & scl_p_reg & sda_p_reg & ~sda_f; // R2
  wire logic  stop_det  = scl_f & scl_p_reg & ~sda_p_reg & sda_f; // R3
  wire logic  addr_hit  = (sh_reg[7:1] == TWS_SLAVE_ADDR);        // R15 R18

  // engine only follows the master's clock; it never drives SCL
  always_comb begin // R1 R7 R14
    st_next    = st_reg;
    cnt_next   = cnt_reg;
    sh_next    = sh_reg;
    dir_next   = dir_reg;
    first_next = first_reg;
    ptr_next   = ptr_reg;
    oe_next    = oe_reg;
    busy_next  = busy_reg;
    wtgl_next  = wtgl_reg;
    wcmd_next  = wcmd_reg;
    rtgl_next  = rtgl_reg;
    rptr_next  = rptr_reg;
    rbyte_next = (rda_s != rda_p_reg) ? rhold_reg : rbyte_reg;
    if (stop_det) begin
      st_next   = TWS_IDLE; // R3
      oe_next   = 1'b0;
      busy_next = 1'b0; // R4
    end else if (start_det) begin
      st_next   = TWS_ADDR; // R5
      cnt_next  = 4'h0;
      oe_next   = 1'b0;
      busy_next = 1'b1; // R4
    end else begin
      unique case (st_reg)
        TWS_IDLE, TWS_IGNORE: begin
        end
        TWS_ADDR, TWS_RX: begin
          if (scl_rise && cnt_reg != TWS_BYTE_BITS) begin
            sh_next  = {sh_reg[6:0], sda_f}; // R6 R10
            cnt_next = cnt_reg + 4'h1;
          end else if (scl_fall && cnt_reg == TWS_BYTE_BITS) begin
            if (st_reg == TWS_ADDR) begin
              if (addr_hit) begin
                oe_next    = 1'b1; // R17
                dir_next   = sh_reg[0]; // R16
                first_next = 1'b1;
                st_next    = TWS_ACK;
              end else begin
                st_next = TWS_IGNORE; // R23
              end
            end else begin
              oe_next = 1'b1; // R11
              st_next = TWS_ACK;
              if (first_reg) begin
                ptr_next   = sh_reg; // R21
                rptr_next  = sh_reg;
                rtgl_next  = ~rtgl_reg;
                first_next = 1'b0;
              end else begin
                wcmd_next = '{addr: ptr_reg, data: sh_reg}; // R20
                wtgl_next = ~wtgl_reg;
                ptr_next  = ptr_reg + 8'h01;
              end
            end
          end
        end
        TWS_ACK: begin
          if (scl_fall) begin
            cnt_next = 4'h0;
            if (dir_reg) begin
              sh_next = rbyte_reg;
              oe_next = ~rbyte_reg[7]; // R19
              st_next = TWS_TX;
            end else begin
              oe_next = 1'b0; // R8
              st_next = TWS_RX;
            end
          end
        end
        TWS_TX: begin
          if (scl_fall) begin // R6 R9
            if (cnt_reg == TWS_LAST_TX_BIT) begin
              oe_next = 1'b0;
              st_next = TWS_TX_ACK;
            end else begin
              sh_next  = {sh_reg[6:0], 1'b0}; // R10
              oe_next  = ~sh_reg[6];
              cnt_next = cnt_reg + 4'h1;
            end
          end
        end
        TWS_TX_ACK: begin
          if (scl_rise) begin
            if (sda_f) begin
              st_next = TWS_IGNORE; // R13 R12
            end else begin
              ptr_next  = ptr_reg + 8'h01;
              rptr_next = ptr_reg + 8'h01;
              rtgl_next = ~rtgl_reg;
              st_next   = TWS_ACK;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge link_clk or posedge lrst_reg) begin
    if (lrst_reg) begin
      st_reg    <= TWS_IDLE;
      cnt_reg   <= 4'h0;
      sh_reg    <= TWS_BYTE_RST;
      dir_reg   <= 1'b0;
      first_reg <= 1'b0;
      ptr_reg   <= TWS_PTR_RST;
      oe_reg    <= 1'b0;
      busy_reg  <= 1'b0;
      wtgl_reg  <= 1'b0;
      wcmd_reg  <= '0;
      rtgl_reg  <= 1'b0;
      rptr_reg  <= TWS_PTR_RST;
      rbyte_reg <= TWS_BYTE_RST;
      scl_p_reg <= 1'b1;
      sda_p_reg <= 1'b1;
      rda_p_reg <= 1'b0;
    end else begin
      st_reg    <= st_next;
      cnt_reg   <= cnt_next;
      sh_reg    <= sh_next;
      dir_reg   <= dir_next;
      first_reg <= first_next;
      ptr_reg   <= ptr_next;
      oe_reg    <= oe_next;
      busy_reg  <= busy_next;
      wtgl_reg  <= wtgl_next;
      wcmd_reg  <= wcmd_next;
      rtgl_reg  <= rtgl_next;
      rptr_reg  <= rptr_next;
      rbyte_reg <= rbyte_next;
      scl_p_reg <= scl_f;
      sda_p_reg <= sda_f;
      rda_p_reg <= rda_s;
    end
  end

  // open drain: only ever pulls low
  assign serial_data_pin_o  = 1'b0; // R19
  assign serial_data_pin_oe = oe_reg; // R8

  // ref side: command words are held stable on the link side until the toggle lands
  always_comb begin
    wr_valid_next = (wtgl_s != wtgl_p_reg);
    wr_cmd_next   = wr_valid_next ? wcmd_reg : wr_cmd_reg;
    rd_req_next   = (rtgl_s != rtgl_p_reg);
    rd_addr_next  = rd_req_next ? rptr_reg : rd_addr_reg;
    rd_pend_next  = rd_req_reg;
    rhold_next    = rd_pend_reg ? rd_data : rhold_reg;
    atgl_next     = rd_pend_reg ? ~atgl_reg : atgl_reg;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wr_valid_reg <= 1'b0;
      wr_cmd_reg   <= '0;
      rd_req_reg   <= 1'b0;
      rd_addr_reg  <= TWS_PTR_RST;
      rd_pend_reg  <= 1'b0;
      rhold_reg    <= TWS_BYTE_RST;
      atgl_reg     <= 1'b0;
      wtgl_p_reg   <= 1'b0;
      rtgl_p_reg   <= 1'b0;
    end else begin
      wr_valid_reg <= wr_valid_next;
      wr_cmd_reg   <= wr_cmd_next;
      rd_req_reg   <= rd_req_next;
      rd_addr_reg  <= rd_addr_next;
      rd_pend_reg  <= rd_pend_next;
      rhold_reg    <= rhold_next;
      atgl_reg     <= atgl_next;
      wtgl_p_reg   <= wtgl_s;
      rtgl_p_reg   <= rtgl_s;
    end
  end

  assign wr_valid = wr_valid_reg;
  assign wr_cmd   = wr_cmd_reg;
  assign rd_req   = rd_req_reg;
  assign rd_addr  = rd_addr_reg;
  assign bus_busy = busy_s;

  // checks
  a_start_addr: assert property (@(posedge link_clk) disable iff (lrst_reg) // R2
    start_det && !stop_det |=> st_reg == TWS_ADDR && busy_reg && cnt_reg == 4'h0)
    else $error("start not taken");
  a_stop_idle: assert property (@(posedge link_clk) disable iff (lrst_reg) // R3
    stop_det |=> st_reg == TWS_IDLE && !busy_reg && !oe_reg) else $error("stop did not idle");
  a_busy_hold: assert property (@(posedge link_clk) disable iff (lrst_reg) // R4
    busy_reg && !stop_det |=> busy_reg) else $error("busy dropped without stop");
  a_sda_stable: assert property (@(posedge link_clk) disable iff (lrst_reg) // R6
    scl_f && scl_p_reg |-> $stable(oe_reg)) else $error("sda moved while scl high");
  a_drive_window: assert property (@(posedge link_clk) disable iff (lrst_reg) // R8
    oe_reg |-> st_reg inside {TWS_ACK, TWS_TX}) else $error("sda driven outside ack or data");
  a_addr_ack: assert property (@(posedge link_clk) disable iff (lrst_reg) // R17
    st_reg == TWS_ADDR && scl_fall && cnt_reg == TWS_BYTE_BITS && addr_hit && !stop_det
    && !start_det |=> oe_reg && st_reg == TWS_ACK && dir_reg == $past(sh_reg[0]))
    else $error("matched address not acknowledged");
  a_foreign_addr: assert property (@(posedge link_clk) disable iff (lrst_reg) // R23
    st_reg == TWS_ADDR && scl_fall && cnt_reg == TWS_BYTE_BITS && !addr_hit && !stop_det
    && !start_det |=> !oe_reg && st_reg == TWS_IGNORE)
    else $error("foreign address answered");
  a_nack_release: assert property (@(posedge link_clk) disable iff (lrst_reg) // R13
    st_reg == TWS_TX_ACK && scl_rise && sda_f && !stop_det && !start_det
    |=> st_reg == TWS_IGNORE ##1 !oe_reg) else $error("read not ended on nack");
  a_msb_first: assert property (@(posedge link_clk) disable iff (lrst_reg) // R10
    st_reg == TWS_ACK && dir_reg && scl_fall && !stop_det && !start_det
    |=> oe_reg == ~$past(rbyte_reg[7])) else $error("first read bit not msb");
  a_wr_strobe: assert property (@(posedge ref_clk) disable iff (rst) // R20
    wtgl_s != wtgl_p_reg |=> wr_valid && wr_cmd == wcmd_reg ##1 !wr_valid)
    else $error("write strobe wrong");

  c_write_done: cover property (@(posedge ref_clk) disable iff (rst) wr_valid);
  c_read_nack: cover property (@(posedge link_clk) disable iff (lrst_reg)
    st_reg == TWS_TX_ACK && scl_rise && sda_f);
  c_restart: cover property (@(posedge link_clk) disable iff (lrst_reg)
    busy_reg && start_det);
  c_foreign: cover property (@(posedge link_clk) disable iff (lrst_reg)
    st_reg == TWS_IGNORE && stop_det);
endmodule

// *** rtl/tws_pkg.sv ***
// shared constants and types for the two-wire slave
// assumes both clocks run continuously while the block is out of reset
package tws_pkg;
  // bus rate ceiling and derived ref_clk cycles per bit
  localparam int          TWS_MAX_RATE_KBPS = 100;
  localparam int          TWS_REF_CLK_MHZ   = 50;
  localparam int          TWS_BIT_CYC       = (TWS_REF_CLK_MHZ * 1000) / TWS_MAX_RATE_KBPS;
  // addressing and framing
  localparam logic [6:0]  TWS_SLAVE_ADDR    = 7'h74;
  localparam logic [3:0]  TWS_BYTE_BITS     = 4'h8;
  localparam logic [3:0]  TWS_LAST_TX_BIT   = 4'h7;
  // reset values
  localparam logic [7:0]  TWS_PTR_RST       = 8'h00;
  localparam logic [7:0]  TWS_BYTE_RST      = 8'h00;
  localparam logic [2:0]  TWS_LINK_SYNC_RST = 3'h6;
  localparam logic [2:0]  TWS_REF_SYNC_RST  = 3'h0;

  typedef enum {
    TWS_IDLE,
    TWS_ADDR,
    TWS_RX,
    TWS_ACK,
    TWS_TX,
    TWS_TX_ACK,
    TWS_IGNORE
  } tws_state_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } tws_wr_s;
endpackage

// *** rtl/tws_sync.sv ***
// three-stage synchroniser with agree filter for pins and toggles
// assumes d is asynchronous to clk; rst is async active high
`timescale 1ns/1ns
module tws_sync
  import tws_pkg::*;
#(
  parameter int           W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] q_reg;
  logic [W-1:0] q_next;
  logic [W-1:0] agree;

  // a level only moves once stages two and three agree; glitches are dropped
  always_comb begin
    agree  = ~(s2_reg ^ s3_reg);
    q_next = (agree & s3_reg) | (~agree & q_reg);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_reg <= INIT;
      s2_reg <= INIT;
      s3_reg <= INIT;
      q_reg  <= INIT;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      q_reg  <= q_next;
    end
  end

  assign q = q_reg;
endmodule

// *** bench/tws_master.sv ***
// bus master model for the two-wire slave: clock pulses, start, stop, bytes
// assumes the bench resolves the open-drain data wire with a pull-up; scl is driven directly
`timescale 1ns/1ns
module tws_master (
  // timing reference
  input  wire logic ref_clk,
  // bus wires
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  // quarter bit of 2.5 us keeps the bus at 100 kbit/s
  localparam int Q = 125;
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end
  task automatic wq(input int n);
    repeat (n * Q) @(negedge ref_clk);
  endtask
  // data moves while scl is low, read back while scl is high
  task automatic put_bit(input logic b, output logic r);
    wq(1);
    sda_low = ~b;
    wq(1);
    scl = 1'b1;
    wq(1);
    r = sda;
    wq(1);
    scl = 1'b0;
  endtask
  // same sequence serves a first and a repeated start
  task automatic start();
    wq(1);
    sda_low = 1'b0;
    wq(1);
    scl = 1'b1;
    wq(2);
    sda_low = 1'b1;
    wq(2);
    scl = 1'b0;
  endtask
  task automatic stop();
    wq(1);
    sda_low = 1'b1;
    wq(1);
    scl = 1'b1;
    wq(2);
    sda_low = 1'b0;
    wq(2);
  endtask
  task automatic tx_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i], r);
    end
    put_bit(1'b1, r);
    ack = ~r;
  endtask
  task automatic rx_byte(input logic give_ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, d[i]);
    end
    put_bit(~give_ack, r);
  endtask
endmodule

// *** bench/tws_slave_bench.sv ***
// self-checking bench for the two-wire slave with a bus master model
// assumes the slave is the only other party on the data wire
`timescale 1ns/1ns
module tws_slave_bench;
  import tws_pkg::*;
  logic       ref_clk;
  logic       link_clk;
  logic       rst = 1'b1;
  logic       scl;
  logic       sda_low;
  logic       sda;
  logic       oe;
  logic       pin_o;
  logic       wr_valid;
  tws_wr_s    wr_cmd;
  logic       rd_req;
  logic [7:0] rd_addr;
  logic [7:0] rd_data = 8'h00;
  logic       bus_busy;
  int         errors = 0;
  int         compares = 0;
  int         seed = 32'h01A7;
  logic [7:0] mem [256];
  logic [7:0] mdl [256];
  tws_wr_s    wr_q [$];
  logic [7:0] rd_q [$];

  // pull-up: the wire is low while either party pulls it
  assign sda = ~(sda_low | oe);

  tws_slave i_dut (
    .ref_clk            (ref_clk),
    .rst                (rst),
    .link_clk           (link_clk),
    .serial_clock_pin   (scl),
    .serial_data_pin_i  (sda),
    .serial_data_pin_o  (pin_o),
    .serial_data_pin_oe (oe),
    .wr_valid           (wr_valid),
    .wr_cmd             (wr_cmd),
    .rd_req             (rd_req),
    .rd_addr            (rd_addr),
    .rd_data            (rd_data),
    .bus_busy           (bus_busy)
  );

  tws_master i_mst (
    .ref_clk (ref_clk),
    .sda     (sda),
    .scl     (scl),
    .sda_low (sda_low)
  );

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #15 link_clk = ~link_clk;
  end

  // user register file: answers a fetch half a cycle later, on the falling edge of ref_clk
  always @(negedge ref_clk) begin
    rd_data <= mem[rd_addr];
  end
  always @(posedge ref_clk) begin
    if (wr_valid === 1'b1) begin
      wr_q.push_back(wr_cmd);
      mem[wr_cmd.addr] <= wr_cmd.data;
    end
    if (rd_req === 1'b1) begin
      rd_q.push_back(rd_addr);
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    if (errors == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic reg_write(input logic [7:0] p, input logic [7:0] d0, input logic [7:0] d1);
    logic a;
    i_mst.start();
    i_mst.tx_byte({TWS_SLAVE_ADDR, 1'b0}, a);
    chk(a, 1);
    chk(bus_busy, 1);
    i_mst.tx_byte(p, a);
    chk(a, 1);
    i_mst.tx_byte(d0, a);
    chk(a, 1);
    i_mst.tx_byte(d1, a);
    chk(a, 1);
    i_mst.stop();
    mdl[p] = d0;
    mdl[8'(p + 8'h01)] = d1;
    chk(16'(wr_q.size()), 2);
    chk(wr_q.pop_front(), {p, d0});
    chk(wr_q.pop_front(), {8'(p + 8'h01), d1});
    chk(16'(rd_q.size()), 1);
    chk(rd_q.pop_front(), p);
    chk(bus_busy, 0);
    chk(oe, 0);
  endtask

  task automatic reg_read(input logic [7:0] p, input int n);
    logic       a;
    logic [7:0] d;
    i_mst.start();
    i_mst.tx_byte({TWS_SLAVE_ADDR, 1'b0}, a);
    chk(a, 1);
    i_mst.tx_byte(p, a);
    chk(a, 1);
    i_mst.start();
    chk(bus_busy, 1);
    i_mst.tx_byte({TWS_SLAVE_ADDR, 1'b1}, a);
    chk(a, 1);
    for (int k = 0; k < n; k++) begin
      i_mst.rx_byte(k < n - 1, d);
      chk(d, mdl[8'(p + k)]);
    end
    i_mst.wq(1);
    chk(sda, 1);
    chk(16'(rd_q.size()), 16'(n));
    for (int k = 0; k < n; k++) begin
      chk(rd_q.pop_front(), 8'(p + k));
    end
    i_mst.stop();
    chk(bus_busy, 0);
  endtask

  initial begin
    logic       a;
    logic [7:0] d;
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'($random(seed));
      mdl[i] = mem[i];
    end
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    repeat (20) @(negedge ref_clk);
    chk(bus_busy, 0);
    // pointer at the top wraps to zero on the second byte
    reg_write(8'hFF, 8'($random(seed)), 8'($random(seed)));
    reg_read(8'hFF, 2);
    i_mst.start();
    i_mst.tx_byte({TWS_SLAVE_ADDR ^ 7'h01, 1'b0}, a);
    chk(a, 0);
    i_mst.tx_byte(8'h5A, a);
    chk(a, 0);
    i_mst.stop();
    chk(16'(wr_q.size()), 0);
    i_mst.start();
    i_mst.tx_byte({7'h34, 1'b1}, a);
    chk(a, 0);
    i_mst.rx_byte(1'b0, d);
    chk(d, 8'hFF);
    i_mst.stop();
    chk(pin_o, 0);
    chk(oe, 0);
    chk(16'(rd_q.size()), 0);
    wrap_up();
  end

  initial begin
    #1900000;
    errors++;
    wrap_up();
  end
endmodule
